// file: logic/mlsp_cfg.svh
// constants of the llc service port: sizes, byte counts and status codes
`ifndef MLSP_CFG_SVH
`define MLSP_CFG_SVH

`define MLSP_ADDR_W      48       // address width in bits
`define MLSP_ADDR_LAST   3'd5     // index of last octet of an address field
`define MLSP_IDX_ZERO    3'd0     // first octet index
`define MLSP_BYTE_W      8        // data path width
`define MLSP_CLASS_W     3        // service class width
`define MLSP_FIFO_DEPTH  16       // request queue depth in words
`define MLSP_RX_DEPTH    64       // receive payload buffer, bytes
`define MLSP_RX_AW       6        // receive buffer address width
`define MLSP_CNT_W       7        // receive byte counter width
`define MLSP_HDR_BYTES   7'd12    // da plus sa octets ahead of the payload
`define MLSP_RX_LIMIT    7'd76    // header plus full buffer
`define MLSP_CNT_ZERO    7'd0
`define MLSP_CNT_ONE     7'd1
`define MLSP_ST_OK       2'h0     // transmission succeeded
`define MLSP_ST_EXCESS   2'h1     // gave up after excessive collisions
`define MLSP_ST_FAIL     2'h2     // other transmit failure

`endif

// file: logic/mlsp_fifo.sv
// parameterised valid/ready fifo used as the transmit request queue
`default_nettype none
module mlsp_fifo #(
    parameter int W = 8,                         // word width
    parameter int D = 16                         // depth, power of two
) (
    input  wire logic         i_clk,             // clock
    input  wire logic         i_srst,            // synchronous reset, active high
    input  wire logic         i_valid,           // write side valid
    input  wire logic [W-1:0] i_data,            // write side word
    output logic              o_ready,           // write side ready, registered
    output logic              o_valid,           // read side valid, registered
    output logic [W-1:0]      o_data,            // read side head word
    input  wire logic         i_ready            // read side ready
);
    localparam int AW = $clog2(D);               // pointer width
    localparam int CW = $clog2(D + 1);           // occupancy width

    logic [W-1:0]  mem [D];                      // storage
    logic [AW-1:0] wr_ptr_reg;                   // write pointer
    logic [AW-1:0] rd_ptr_reg;                   // read pointer
    logic [CW-1:0] cnt_reg;                      // occupancy
    logic [CW-1:0] cnt_next;                     // next occupancy
    logic          push;                         // word taken
    logic          pop;                          // word given

    assign push     = i_valid && o_ready;
    assign pop      = o_valid && i_ready;
    assign cnt_next = cnt_reg + CW'(push) - CW'(pop);
    assign o_data   = mem[rd_ptr_reg];

    // storage write, no reset needed on data
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_data;
        end
    end

    // pointers and flags; ready and valid are flops so the top sees clean edges
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
            o_ready    <= 1'b0;
            o_valid    <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            cnt_reg    <= cnt_next;
            o_ready    <= cnt_next != CW'(D);    // holds off the requester when full, see [R12]
            o_valid    <= cnt_next != '0;
        end
    end

    a_full_holds: assert property (@(posedge i_clk) disable iff (i_srst) // see [R12]
        (!o_ready && !pop) |=> (cnt_reg == $past(cnt_reg)))
        else $error("queue grew while full");
endmodule : mlsp_fifo
`default_nettype wire

// file: logic/mlsp_pkg.sv
// types shared by the llc service port
`default_nettype none
package mlsp_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_DA, TX_SA, TX_PAY, TX_WAIT, TX_CNF} mlsp_tx_t;  // transmit sequencer
    typedef enum logic [0:0] {RX_COL, RX_OUT} mlsp_rx_t;                                  // receive collect / deliver
endpackage : mlsp_pkg
`default_nettype wire

// file: logic/mlsp_port.sv
// media access controller service port toward the logical link layer
// Functional notes
// [R1] add da and sa, forward frame downward
// [R2] requester supplies individual or group destination
// [R3] requester marks data unit end explicitly
// [R4] class accepted, one service for all
// [R5] exactly one confirm per request
// [R6] confirm reports success, collisions or failure
// [R7] requests served first in, first out
// [R8] request, confirm and indication all present
// [R9] upper layer may reset the controller
// [R10] deliver only good, addressed, well formed frames
// [R11] frames sent to ourselves also delivered
// [R12] valid/ready handshakes, hold off when full
`include "mlsp_cfg.svh"
`default_nettype none
module mlsp_port
    import mlsp_pkg::*;
(
    input  wire logic                     i_clk,          // 100 mhz clock
    input  wire logic                     i_srst,         // synchronous reset, active high
    input  wire logic                     i_llc_reset,    // reset request from the upper layer
    input  wire logic [`MLSP_ADDR_W-1:0]  i_station_addr, // our individual address, octet 0 in bits 7:0
    input  wire logic                     i_req_valid,    // request byte valid
    input  wire logic [`MLSP_BYTE_W-1:0]  i_req_data,     // request data byte
    input  wire logic                     i_req_last,     // last byte of the data unit
    input  wire logic [`MLSP_ADDR_W-1:0]  i_req_dst,      // destination, held for the whole request
    input  wire logic [`MLSP_CLASS_W-1:0] i_req_class,    // service class, accepted and ignored
    output logic                          o_req_ready,    // request byte taken
    output logic                          o_phy_valid,    // frame byte to the physical layer
    output logic [`MLSP_BYTE_W-1:0]       o_phy_data,     // frame byte
    output logic                          o_phy_last,     // last frame byte
    input  wire logic                     i_phy_ready,    // physical layer takes byte
    input  wire logic                     i_phy_done,     // transmit attempt finished, pulse
    input  wire logic                     i_phy_excess,   // with done: excessive collisions
    input  wire logic                     i_phy_fail,     // with done: other failure
    output logic                          o_cnf_valid,    // confirmation valid
    output logic [1:0]                    o_cnf_status,   // transmission status
    input  wire logic                     i_cnf_ready,    // confirmation taken
    input  wire logic                     i_rx_valid,     // received byte valid
    input  wire logic [`MLSP_BYTE_W-1:0]  i_rx_data,      // received byte
    input  wire logic                     i_rx_last,      // last received byte
    input  wire logic                     i_rx_err,       // with last: frame had an error
    output logic                          o_ind_valid,    // indication byte valid
    output logic [`MLSP_BYTE_W-1:0]       o_ind_data,     // indication payload byte
    output logic                          o_ind_last,     // last payload byte
    output logic [`MLSP_ADDR_W-1:0]       o_ind_dst,      // destination of delivered frame
    output logic [`MLSP_ADDR_W-1:0]       o_ind_src,      // source of delivered frame
    input  wire logic                     i_ind_ready     // indication byte taken
);
    localparam int QW = `MLSP_ADDR_W + 1 + `MLSP_BYTE_W;  // queue word: dst, last, data

    logic                        rst;                     // hardware or upper layer reset
    logic                        q_valid;                 // queue head valid
    logic [QW-1:0]               q_data;                  // queue head word
    logic                        q_pop;                   // queue head consumed
    logic                        load;                    // phy output stage may load
    mlsp_tx_t                    tx_state_reg;            // transmit sequencer
    logic [2:0]                  idx_reg;                 // address octet index
    logic [`MLSP_ADDR_W-1:0]     dst_reg;                 // destination of frame in flight
    logic                        loop_reg;                // frame in flight is for us too
    logic [`MLSP_BYTE_W-1:0]     da_byte;                 // current destination octet
    logic [`MLSP_BYTE_W-1:0]     sa_byte;                 // current source octet
    logic                        cap_v;                   // capture beat
    logic [`MLSP_BYTE_W-1:0]     cap_d;                   // capture byte
    logic                        cap_last;                // capture frame end
    logic                        cap_err;                 // capture frame error
    mlsp_rx_t                    rx_state_reg;            // receive state
    logic [`MLSP_CNT_W-1:0]      rx_cnt_reg;              // bytes seen in this frame
    logic                        rx_ovf_reg;              // payload longer than buffer
    logic                        rx_skip_reg;             // dropping a frame that started while busy
    logic [`MLSP_CNT_W-1:0]      rx_len_reg;              // payload bytes to deliver
    logic [`MLSP_CNT_W-1:0]      rd_idx_reg;              // delivery index
    logic                        rd_done_reg;             // last byte loaded
    logic [`MLSP_BYTE_W-1:0]     rx_mem [`MLSP_RX_DEPTH]; // receive payload buffer
    logic [`MLSP_CNT_W-1:0]      pay_idx;                 // payload index of current byte
    logic                        rx_good;                 // frame end qualifies for delivery
    logic                        ind_load;                // indication stage may load

    // either reset brings every state machine to idle, see [R9]
    assign rst = i_srst || i_llc_reset;

    // all group addresses (broadcast among them) are accepted: there is no filter table
    function automatic logic addr_hit(input logic [`MLSP_ADDR_W-1:0] a, input logic [`MLSP_ADDR_W-1:0] me);
        return (a == me) || a[0];
    endfunction : addr_hit

    // class is taken with each byte but never steers anything: one quality of service, see [R4]
    mlsp_fifo #(.W(QW), .D(`MLSP_FIFO_DEPTH)) u_req_q (
        .i_clk   (i_clk),
        .i_srst  (rst),
        .i_valid (i_req_valid),
        .i_data  ({i_req_dst, i_req_last, i_req_data}),
        .o_ready (o_req_ready),
        .o_valid (q_valid),
        .o_data  (q_data),
        .i_ready (q_pop)
    );

    assign load    = !o_phy_valid || i_phy_ready;
    assign q_pop   = (tx_state_reg == TX_PAY) && load && q_valid;
    assign da_byte = dst_reg[{idx_reg, 3'h0} +: `MLSP_BYTE_W];
    assign sa_byte = i_station_addr[{idx_reg, 3'h0} +: `MLSP_BYTE_W];

    // transmit sequencer: one request at a time, next one only after its confirm, see [R7]
    always_ff @(posedge i_clk) begin
        if (rst) begin
            tx_state_reg <= TX_IDLE;
            idx_reg      <= `MLSP_IDX_ZERO;
            dst_reg      <= '0;
            loop_reg     <= 1'b0;
            o_phy_valid  <= 1'b0;
            o_phy_data   <= '0;
            o_phy_last   <= 1'b0;
            o_cnf_valid  <= 1'b0;
            o_cnf_status <= `MLSP_ST_OK;
        end else begin
            case (tx_state_reg)
                TX_IDLE: begin                                  // wait for a queued request
                    if (q_valid) begin
                        dst_reg      <= q_data[QW-1 -: `MLSP_ADDR_W];
                        loop_reg     <= addr_hit(q_data[QW-1 -: `MLSP_ADDR_W], i_station_addr); // see [R11]
                        idx_reg      <= `MLSP_IDX_ZERO;
                        tx_state_reg <= TX_DA;
                    end
                end
                TX_DA: begin                                    // destination field, see [R1]
                    if (load) begin
                        o_phy_valid <= 1'b1;
                        o_phy_data  <= da_byte;
                        o_phy_last  <= 1'b0;
                        idx_reg     <= (idx_reg == `MLSP_ADDR_LAST) ? `MLSP_IDX_ZERO : idx_reg + 3'h1;
                        if (idx_reg == `MLSP_ADDR_LAST) begin
                            tx_state_reg <= TX_SA;
                        end
                    end
                end
                TX_SA: begin                                    // source field from our address, see [R1]
                    if (load) begin
                        o_phy_data  <= sa_byte;
                        idx_reg     <= (idx_reg == `MLSP_ADDR_LAST) ? `MLSP_IDX_ZERO : idx_reg + 3'h1;
                        if (idx_reg == `MLSP_ADDR_LAST) begin
                            tx_state_reg <= TX_PAY;
                        end
                    end
                end
                TX_PAY: begin                                   // data unit until its end mark, see [R1]
                    if (load) begin
                        o_phy_valid <= q_valid;
                        o_phy_data  <= q_data[`MLSP_BYTE_W-1:0];
                        o_phy_last  <= q_valid && q_data[`MLSP_BYTE_W];
                        if (q_valid && q_data[`MLSP_BYTE_W]) begin
                            tx_state_reg <= TX_WAIT;
                        end
                    end
                end
                TX_WAIT: begin                                  // drain last byte, await outcome
                    if (load) begin
                        o_phy_valid <= 1'b0;
                        o_phy_last  <= 1'b0;
                    end
                    if (i_phy_done) begin                       // see [R6]
                        o_cnf_valid  <= 1'b1;
                        o_cnf_status <= i_phy_excess ? `MLSP_ST_EXCESS :
                                        (i_phy_fail ? `MLSP_ST_FAIL : `MLSP_ST_OK);
                        tx_state_reg <= TX_CNF;
                    end
                end
                TX_CNF: begin                                   // single confirm, see [R5]
                    if (i_cnf_ready) begin
                        o_cnf_valid  <= 1'b0;
                        loop_reg     <= 1'b0;
                        tx_state_reg <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // capture source: our own frame when it is addressed to us, else the line; the loop
    // takes priority, so a line frame overlapping a send addressed to us is lost; sends to others leave the line heard
    assign cap_v    = loop_reg ? (o_phy_valid && i_phy_ready) : i_rx_valid;   // see [R11]
    assign cap_d    = loop_reg ? o_phy_data : i_rx_data;
    assign cap_last = loop_reg ? o_phy_last : i_rx_last;
    assign cap_err  = loop_reg ? 1'b0 : i_rx_err;
    assign pay_idx  = rx_cnt_reg - `MLSP_HDR_BYTES;
    assign rx_good  = !cap_err && !rx_ovf_reg && (rx_cnt_reg >= `MLSP_HDR_BYTES)
                      && (rx_cnt_reg < `MLSP_RX_LIMIT)                         // a 65th payload byte is too long
                      && addr_hit(o_ind_dst, i_station_addr);                  // see [R10]
    assign ind_load = !o_ind_valid || i_ind_ready;

    // payload buffer write; the whole frame is held so a bad one is never shown;
    // bytes past the buffer are not written, so a too long frame cannot wrap onto entry 0
    always_ff @(posedge i_clk) begin
        if (rx_state_reg == RX_COL && cap_v && !rx_skip_reg && !rx_ovf_reg
            && rx_cnt_reg >= `MLSP_HDR_BYTES && rx_cnt_reg < `MLSP_RX_LIMIT) begin
            rx_mem[pay_idx[`MLSP_RX_AW-1:0]] <= cap_d;
        end
    end

    // receive collection, address capture and frame qualification
    always_ff @(posedge i_clk) begin
        if (rst) begin
            rx_state_reg <= RX_COL;
            rx_cnt_reg   <= `MLSP_CNT_ZERO;
            rx_ovf_reg   <= 1'b0;
            rx_skip_reg  <= 1'b0;
            rx_len_reg   <= `MLSP_CNT_ZERO;
            o_ind_dst    <= '0;
            o_ind_src    <= '0;
        end else if (rx_state_reg == RX_OUT) begin
            if (cap_v) begin                                    // busy delivering: drop arrivals
                rx_skip_reg <= !cap_last;
            end
            if (ind_load && rd_done_reg) begin
                rx_state_reg <= RX_COL;
            end
        end else if (cap_v) begin
            if (rx_skip_reg) begin                              // tail of a dropped frame
                rx_skip_reg <= !cap_last;
            end else if (cap_last) begin
                rx_cnt_reg <= `MLSP_CNT_ZERO;
                rx_ovf_reg <= 1'b0;
                rx_len_reg <= pay_idx + `MLSP_CNT_ONE;
                if (rx_good) begin                              // see [R10]
                    rx_state_reg <= RX_OUT;
                end
            end else begin
                if (rx_cnt_reg < `MLSP_HDR_BYTES) begin         // shift address octets in, first octet lowest
                    {o_ind_src, o_ind_dst} <= {cap_d, o_ind_src, o_ind_dst[`MLSP_ADDR_W-1:`MLSP_BYTE_W]};
                end
                if (rx_cnt_reg == `MLSP_RX_LIMIT) begin
                    rx_ovf_reg <= 1'b1;
                end else begin
                    rx_cnt_reg <= rx_cnt_reg + `MLSP_CNT_ONE;
                end
            end
        end
    end

    // indication output stage: payload bytes of a qualified frame, in order, see [R8]
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_ind_valid <= 1'b0;
            o_ind_data  <= '0;
            o_ind_last  <= 1'b0;
            rd_idx_reg  <= `MLSP_CNT_ZERO;
            rd_done_reg <= 1'b0;
        end else if (rx_state_reg == RX_OUT && ind_load) begin
            o_ind_valid <= !rd_done_reg;
            o_ind_data  <= rx_mem[rd_idx_reg[`MLSP_RX_AW-1:0]];
            o_ind_last  <= !rd_done_reg && (rd_idx_reg + `MLSP_CNT_ONE == rx_len_reg);
            rd_idx_reg  <= rd_done_reg ? `MLSP_CNT_ZERO : rd_idx_reg + `MLSP_CNT_ONE;
            rd_done_reg <= !rd_done_reg && (rd_idx_reg + `MLSP_CNT_ONE == rx_len_reg);
        end else if (ind_load) begin
            o_ind_valid <= 1'b0;
            o_ind_last  <= 1'b0;
        end
    end

    a_da_first: assert property (@(posedge i_clk) disable iff (rst) // see [R1]
        (tx_state_reg == TX_DA && load && idx_reg == `MLSP_IDX_ZERO)
        |=> (o_phy_valid && o_phy_data == dst_reg[`MLSP_BYTE_W-1:0]))
        else $error("destination octet not sent first");
    a_sa_bytes: assert property (@(posedge i_clk) disable iff (rst) // see [R1]
        (tx_state_reg == TX_SA && load) |=> (o_phy_data == $past(sa_byte) && !o_phy_last))
        else $error("source octet wrong");
    a_cnf_after_done: assert property (@(posedge i_clk) disable iff (rst) // see [R5]
        (tx_state_reg == TX_WAIT && i_phy_done) |=> (o_cnf_valid && tx_state_reg == TX_CNF))
        else $error("no confirm after transmit outcome");
    a_cnf_single: assert property (@(posedge i_clk) disable iff (rst) // see [R5]
        (o_cnf_valid && i_cnf_ready) |=> (!o_cnf_valid ##1 !o_cnf_valid))
        else $error("confirm repeated");
    a_cnf_excess: assert property (@(posedge i_clk) disable iff (rst) // see [R6]
        (tx_state_reg == TX_WAIT && i_phy_done && i_phy_excess) |=> (o_cnf_status == `MLSP_ST_EXCESS))
        else $error("collision failure not reported");
    a_fifo_order: assert property (@(posedge i_clk) disable iff (rst) // see [R7]
        o_cnf_valid |-> (!q_pop && tx_state_reg == TX_CNF))
        else $error("next request started before confirm");
    a_bad_dropped: assert property (@(posedge i_clk) disable iff (rst) // see [R10]
        (rx_state_reg == RX_COL && cap_v && cap_last && !rx_skip_reg && !rx_good) |=> (rx_state_reg == RX_COL))
        else $error("bad frame delivered");
    a_loop_source: assert property (@(posedge i_clk) disable iff (rst) // see [R11]
        (loop_reg && o_phy_valid && i_phy_ready && o_phy_last) |-> (cap_v && cap_last && !cap_err))
        else $error("own frame not looped back");
endmodule : mlsp_port
`default_nettype wire

// file: verification/mlsp_phy_model.sv
// physical layer stand-in: byte sink with stall and a scripted attempt outcome
`default_nettype none
module mlsp_phy_model (
    input  wire logic       i_clk,    // clock
    input  wire logic       i_stall,  // hold off frame bytes
    input  wire logic [1:0] i_mode,   // outcome: 0 ok, 1 excess, 2 fail
    input  wire logic       i_valid,  // byte offered
    input  wire logic       i_last,   // final byte offered
    output logic            o_ready,  // byte taken
    output logic            o_done,   // attempt over, one cycle
    output logic            o_excess, // qualifies done
    output logic            o_fail    // qualifies done
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;                      // cycles until the outcome pulse
    assign o_ready = !i_stall;
    initial {o_done, o_excess, o_fail} = 3'h0;
    // outcome three cycles after the last byte; qualifiers follow the mode every cycle, not only with done, so done must gate them
    always @(posedge i_clk) begin
        cnt <= (i_valid && o_ready && i_last) ? 3 : (cnt > 0 ? cnt - 1 : 0);
        o_done <= #1 (cnt == 1);
        o_excess <= #1 i_mode[0];
        o_fail <= #1 i_mode[1];
    end
endmodule : mlsp_phy_model
`default_nettype wire

// file: verification/mlsp_port_tb_top.sv
// testbench: drives the llc side and the receive line, watches phy, confirm and indication streams
`include "mlsp_cfg.svh"
`default_nettype none
module mlsp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [47:0] STA = 48'h665544332212; // our individual address
    localparam logic [47:0] OTH = 48'h0a0908070604; // some other station
    localparam logic [47:0] RSA = 48'h00000000ab02; // source of line frames
    logic clk = 0, srst = 1, llc_rst = 0, rq_v = 0, rq_l = 0, rq_rdy, pv, pl, pr, pdone, pex, pfail, cv, iv, il;
    logic rv = 0, rl = 0, re = 0, stall = 0, cr = 1;
    logic [7:0] rq_d = 8'h00, rd = 8'h00, pd, id;
    logic [47:0] dst = 48'h0, isrc, idst, src_seen, dst_seen;
    logic [2:0] cls = 3'h0;
    logic [1:0] cst, mode = 2'h0;
    logic [8:0] phy_q[$], ind_q[$];   // {last, byte} as accepted
    logic [1:0] cnf_q[$];             // statuses in hand-off order
    int n_errors = 0, samples_checked = 0, cyc = 0, refused = 0;
    always #5 clk = !clk;
    mlsp_port i_mlsp_port (.i_clk(clk), .i_srst(srst), .i_llc_reset(llc_rst), .i_station_addr(STA),
        .i_req_valid(rq_v), .i_req_data(rq_d), .i_req_last(rq_l), .i_req_dst(dst), .i_req_class(cls),
        .o_req_ready(rq_rdy), .o_phy_valid(pv), .o_phy_data(pd), .o_phy_last(pl), .i_phy_ready(pr),
        .i_phy_done(pdone), .i_phy_excess(pex), .i_phy_fail(pfail), .o_cnf_valid(cv), .o_cnf_status(cst),
        .i_cnf_ready(cr), .i_rx_valid(rv), .i_rx_data(rd), .i_rx_last(rl), .i_rx_err(re), .o_ind_valid(iv),
        .o_ind_data(id), .o_ind_last(il), .o_ind_dst(idst), .o_ind_src(isrc), .i_ind_ready(1'b1));
    mlsp_phy_model i_mlsp_phy_model (.i_clk(clk), .i_stall(stall), .i_mode(mode), .i_valid(pv),
        .i_last(pl), .o_ready(pr), .o_done(pdone), .o_excess(pex), .o_fail(pfail));
    // monitor; a confirm counts once, at the edge where ready meets valid; outcome cycles 0,1,2
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pv && pr) phy_q.push_back({pl, pd});
        if (cv && cr) cnf_q.push_back(cst);
        if (cv && cr) mode <= #1 (mode == 2'h2) ? 2'h0 : mode + 2'h1;
        if (iv) ind_q.push_back({il, id});
        if (iv) src_seen <= isrc;
        if (iv) dst_seen <= idst;
        if (cyc == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task chk(string what, logic [63:0] seen, logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    // one data unit, class changed per byte; waits for ready at each edge
    task send(logic [47:0] d, int n, logic [7:0] base);
        for (int k = 0; k < n; k++) begin
            rq_v = 1;
            rq_d = 8'(base + k);
            rq_l = (k == n - 1);
            dst = d;
            cls = 3'(k);
            do begin
                @(posedge clk);
                refused += (rq_rdy !== 1'b1);
            end while (rq_rdy !== 1'b1);
            #1;
        end
        rq_v = 0;
        rq_d = ~rq_d;
        dst = ~dst;
    endtask : send
    task chk_frame(logic [47:0] d, int n, logic [7:0] base);
        logic [8:0] e;
        for (int k = 0; k < 12 + n; k++) begin
            e = k < 6 ? {1'b0, d[8*k+:8]} : k < 12 ? {1'b0, STA[8*(k-6)+:8]} : {k == 11 + n, 8'(base + k - 12)};
            chk("phy byte", phy_q.size() > 0 ? phy_q.pop_front() : 9'h1ff, e);
        end
    endtask : chk_frame
    task settle(int nc, int ni);
        for (int k = 0; k < 600 && (cnf_q.size() < nc || ind_q.size() < ni); k++) @(posedge clk);
        repeat (6) @(posedge clk);
        #1;
        chk("confirm count", cnf_q.size(), nc);
        chk("indication count", ind_q.size(), ni);
    endtask : settle
    task rx(logic [47:0] da, logic err);
        for (int k = 0; k < 15; k++) begin
            rv = 1;
            rd = k < 6 ? da[8*k+:8] : k < 12 ? RSA[8*(k-6)+:8] : 8'(8'h60 + k - 12);
            rl = (k == 14);
            re = err;
            @(posedge clk);
            #1;
        end
        rv = 0;
        rd = ~rd;
        rl = 0;
        re = !err;
        repeat (8) @(posedge clk);
        #1;
    endtask : rx
    // broadcast sent by us comes back up as well
    task t_loop;
        send(48'hffffffffffff, 3, 8'h10);
        settle(1, 3);
        chk_frame(48'hffffffffffff, 3, 8'h10);
        chk("status", cnf_q.pop_front(), `MLSP_ST_OK);
        for (int k = 0; k < 3; k++) chk("self ind", ind_q.pop_front(), {k == 2, 8'(8'h10 + k)});
        chk("self src", src_seen, STA);
        chk("self dst", dst_seen, 48'hffffffffffff);
        $display("test loopback done");
    endtask : t_loop
    // queue overfilled while phy stalls, first confirm held waiting, outcomes excess then fail
    task t_fifo;
        refused = 0;
        stall = 1;
        cr = 0;
        fork
            begin
                send(OTH, 20, 8'h40);
                @(posedge clk);
                #1;
                send(OTH, 2, 8'h80);
            end
            begin
                repeat (40) @(posedge clk);
                #1 stall = 0;
                repeat (60) @(posedge clk);
                #1 cr = 1;
            end
        join
        settle(2, 0);
        chk("held off", refused > 0, 1);
        chk_frame(OTH, 20, 8'h40);
        chk_frame(OTH, 2, 8'h80);
        chk("status 1", cnf_q.pop_front(), `MLSP_ST_EXCESS);
        chk("status 2", cnf_q.pop_front(), `MLSP_ST_FAIL);
        $display("test queue done");
    endtask : t_fifo
    // line frames: only the good one addressed to us is delivered
    task t_rx;
        rx(STA, 0);
        rx(STA, 1);
        rx(OTH, 0);
        settle(0, 3);
        for (int k = 0; k < 3; k++) chk("rx ind", ind_q.pop_front(), {k == 2, 8'(8'h60 + k)});
        chk("rx src", src_seen, RSA);
        chk("rx dst", dst_seen, STA);
        $display("test receive done");
    endtask : t_rx
    task t_rst;
        llc_rst = 1;
        @(posedge clk);
        #1;
        chk("ready in reset", rq_rdy, 0);
        llc_rst = 0;
        @(posedge clk);
        #1;
        chk("ready after reset", rq_rdy, 1);
        $display("test reset done");
    endtask : t_rst
    task wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge clk);
        #1 srst = 0;
        @(posedge clk);
        #1;
        t_loop();
        t_fifo();
        t_rx();
        t_rst();
        wrap_up();
    end
endmodule : mlsp_port_tb_top
`default_nettype wire
